// File: rtl/sadc_cfg.svh
// Constants shared by both ends of the serial converter control link.
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH

// ----------------------------------------------------------------------
// Link and sequence constants.
// ----------------------------------------------------------------------
`define SADC_ADDR_W 5
`define SADC_DATA_W 8
`define SADC_SEL_RISES 2'h2
`define SADC_SAMPLE_FALL 4'h4
`define SADC_LAST_FALL 4'h7
`define SADC_CONV_LAST 6'h23
`define SADC_SELF_TEST_CH 5'h13
`define SADC_LAST_EXT_CH 5'h12
`define SADC_SELF_TEST_CODE 8'h80
`define SADC_LINE_IDLE 1'h1
// Idle pin levels {select, address, shift clock, conversion clock}.
`define SADC_PIN_IDLE 4'h8

// ----------------------------------------------------------------------
// Host timing: half periods in cycles of the 8 ns system clock, waits in conversion-clock falls.
// ----------------------------------------------------------------------
`define SADC_IO_HALF 4'h8
`define SADC_SYS_HALF 4'h8
`define SADC_SEL_FALLS_NORM 6'h3
`define SADC_SEL_FALLS_COMMON 6'h2
`define SADC_CONV_WAIT 6'h28

// ----------------------------------------------------------------------
// Synchroniser bit positions.
// ----------------------------------------------------------------------
`define SADC_SY_SYS 0
`define SADC_SY_IO 1
`define SADC_SY_ADDR 2
`define SADC_SY_CS 3

`endif

// File: rtl/sadc_pkg.sv
// Types shared by both ends of the serial converter control link.
package sadc_pkg;

    // ------------------------------------------------------------------
    // Device sequence phase.
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        SADC_PH_OFF,
        SADC_PH_SHIFT
    } sadc_phase_e;

    // ------------------------------------------------------------------
    // Host sequence state.
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SADC_H_IDLE,
        SADC_H_SEL,
        SADC_H_SHIFT,
        SADC_H_CONV
    } sadc_hstate_e;

endpackage

// File: rtl/sadc_if.sv
// Serial control link between the converter device and its host.
`timescale 1ns/1ns
`include "sadc_cfg.svh"

interface sadc_if;
    logic cs_n;
    logic addr;
    logic io_clk;
    logic sys_clk;
    logic dout;
    logic dout_oe_n;
    logic dout_line;

    // The floating output is seen as a pulled-up line.
    assign dout_line = dout_oe_n ? `SADC_LINE_IDLE : dout;

    modport dev (
        input cs_n,
        input addr,
        input io_clk,
        input sys_clk,
        output dout,
        output dout_oe_n
    );

    modport host (
        output cs_n,
        output addr,
        output io_clk,
        output sys_clk,
        input dout_line
    );
endinterface

// File: rtl/sadc_dev.sv
// Device end: select recognition, serial shift, sample, hold and conversion.
`timescale 1ns/1ns
`include "sadc_cfg.svh"

module sadc_dev (
    input wire logic clk_i, // System clock, 125 MHz.
    input wire logic resetn_i, // Asynchronous reset, active low.
    sadc_if.dev link, // Serial control link.
    input wire logic [`SADC_DATA_W-1:0] conv_data_i, // Converter core code.
    output logic [`SADC_ADDR_W-1:0] chan_o, // Selected analog channel.
    output logic sample_o, // Sample switch closed.
    output logic convert_o, // Hold and conversion running.
    output logic [`SADC_DATA_W-1:0] result_o, // Last finished result.
    output logic done_o // One-cycle pulse at conversion end.
);

    // ------------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------------
    // Edge of a synchronised level against its previous sample.
    function automatic logic sadc_edge(input logic cur, input logic prev, input logic pol);
        sadc_edge = (cur == pol) && (prev != pol);
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers.
    // ------------------------------------------------------------------
    logic [3:0] sy1_r;
    logic [3:0] sy2_r;
    logic [3:0] sy3_r;
    logic [3:0] pins;
    logic sys_rise;
    logic sys_fall;
    logic io_rise;
    logic io_fall;

    assign pins = {link.cs_n, link.addr, link.io_clk, link.sys_clk};

    // Two stages before any logic, a third only for edge finding.
    // Reset to the idle pin levels so no false clock edge follows reset.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sy1_r <= `SADC_PIN_IDLE;
            sy2_r <= `SADC_PIN_IDLE;
            sy3_r <= `SADC_PIN_IDLE;
        end else begin
            sy1_r <= pins;
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
        end
    end

    // Both link clocks are found by sampling, so no phase tie is needed.
    assign sys_rise = sadc_edge(sy2_r[`SADC_SY_SYS], sy3_r[`SADC_SY_SYS], 1'h1);
    assign sys_fall = sadc_edge(sy2_r[`SADC_SY_SYS], sy3_r[`SADC_SY_SYS], 1'h0);
    assign io_rise = sadc_edge(sy2_r[`SADC_SY_IO], sy3_r[`SADC_SY_IO], 1'h1);
    assign io_fall = sadc_edge(sy2_r[`SADC_SY_IO], sy3_r[`SADC_SY_IO], 1'h0);

    // ------------------------------------------------------------------
    // Select recognition.
    // ------------------------------------------------------------------
    logic cs_rec_r;
    logic cs_rec_nxt;
    logic [1:0] cs_rises_r;
    logic [1:0] cs_rises_nxt;
    logic cs_fell;
    logic cs_rose;

    // A pin change counts only after two conversion-clock rises and a
    // fall; a glitch shorter than that restarts the count and is lost.
    always_comb begin
        cs_rec_nxt = cs_rec_r;
        cs_rises_nxt = cs_rises_r;
        if (sy2_r[`SADC_SY_CS] == cs_rec_r) begin
            cs_rises_nxt = 2'h0;
        end else if (sys_rise && (cs_rises_r != `SADC_SEL_RISES)) begin
            cs_rises_nxt = cs_rises_r + 2'h1;
        end else if (sys_fall && (cs_rises_r == `SADC_SEL_RISES)) begin
            cs_rec_nxt = sy2_r[`SADC_SY_CS];
            cs_rises_nxt = 2'h0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cs_rec_r <= 1'h1;
            cs_rises_r <= 2'h0;
        end else begin
            cs_rec_r <= cs_rec_nxt;
            cs_rises_r <= cs_rises_nxt;
        end
    end

    assign cs_fell = cs_rec_r && !cs_rec_nxt;
    assign cs_rose = !cs_rec_r && cs_rec_nxt;

    // ------------------------------------------------------------------
    // Serial sequence and conversion.
    // ------------------------------------------------------------------
    sadc_pkg::sadc_phase_e phase_r;
    sadc_pkg::sadc_phase_e phase_nxt;
    logic [3:0] falls_r;
    logic [3:0] falls_nxt;
    logic [`SADC_DATA_W-1:0] shreg_r;
    logic [`SADC_DATA_W-1:0] shreg_nxt;
    logic [`SADC_ADDR_W-1:0] new_addr_r;
    logic [`SADC_ADDR_W-1:0] new_addr_nxt;
    logic [`SADC_ADDR_W-1:0] chan_r;
    logic [`SADC_ADDR_W-1:0] chan_nxt;
    logic [`SADC_ADDR_W-1:0] conv_ch_r;
    logic [`SADC_ADDR_W-1:0] conv_ch_nxt;
    logic sample_r;
    logic sample_nxt;
    logic busy_r;
    logic busy_nxt;
    logic [5:0] conv_cnt_r;
    logic [5:0] conv_cnt_nxt;
    logic [`SADC_DATA_W-1:0] result_r;
    logic [`SADC_DATA_W-1:0] result_nxt;
    logic done_r;
    logic done_nxt;
    logic dout_r;
    logic dout_nxt;
    logic oe_n_r;
    logic oe_n_nxt;
    logic shifting;

    // Shift edges count only while select is recognized low.
    assign shifting = !cs_rec_r && (phase_r == sadc_pkg::SADC_PH_SHIFT);

    always_comb begin
        phase_nxt = phase_r;
        falls_nxt = falls_r;
        shreg_nxt = shreg_r;
        new_addr_nxt = new_addr_r;
        chan_nxt = chan_r;
        conv_ch_nxt = conv_ch_r;
        sample_nxt = sample_r;
        busy_nxt = busy_r;
        conv_cnt_nxt = conv_cnt_r;
        result_nxt = result_r;
        done_nxt = 1'h0;
        dout_nxt = dout_r;
        oe_n_nxt = oe_n_r;

        // Conversion runs on conversion-clock rises until a recognized select fall;
        // with a shared clock this is the clock seen while select is high.
        if (busy_r && sys_rise) begin
            if (conv_cnt_r == `SADC_CONV_LAST) begin
                busy_nxt = 1'h0;
                done_nxt = 1'h1;
                // The internal test voltage converts to mid-scale.
                if (conv_ch_r == `SADC_SELF_TEST_CH) begin
                    result_nxt = `SADC_SELF_TEST_CODE;
                end else begin
                    result_nxt = conv_data_i;
                end
                // Select held low between conversions: offer the new MSB.
                if (shifting && (falls_r == 4'h0)) begin
                    shreg_nxt = result_nxt;
                    dout_nxt = result_nxt[`SADC_DATA_W-1];
                end
            end else begin
                conv_cnt_nxt = conv_cnt_r + 6'h1;
            end
        end

        if (cs_fell) begin
            // A recognized select fall restarts the frame and kills any
            // conversion still running; the stored result is kept.
            busy_nxt = 1'h0;
            phase_nxt = sadc_pkg::SADC_PH_SHIFT;
            falls_nxt = 4'h0;
            shreg_nxt = result_nxt;
            dout_nxt = result_nxt[`SADC_DATA_W-1];
            oe_n_nxt = 1'h0;
        end else if (cs_rose) begin
            // Output floats and shift edges are ignored from here.
            phase_nxt = sadc_pkg::SADC_PH_OFF;
            falls_nxt = 4'h0;
            sample_nxt = 1'h0;
            oe_n_nxt = 1'h1;
        end else if (shifting) begin
            // Clocks before recognition never get here, which is what
            // spends the first two shared clocks of a frame.
            if (io_rise && (falls_r <= `SADC_SAMPLE_FALL)) begin
                new_addr_nxt = {new_addr_r[`SADC_ADDR_W-2:0], sy2_r[`SADC_SY_ADDR]};
            end
            if (io_fall) begin
                if (falls_r == `SADC_LAST_FALL) begin
                    // Eighth fall, however late for a strobed start, ends
                    // sampling and restarts conversion; a running one is
                    // dropped and the older result is offered.
                    sample_nxt = 1'h0;
                    busy_nxt = 1'h1;
                    conv_cnt_nxt = 6'h0;
                    conv_ch_nxt = chan_r;
                    falls_nxt = 4'h0;
                    shreg_nxt = result_nxt;
                    dout_nxt = result_nxt[`SADC_DATA_W-1];
                end else begin
                    falls_nxt = falls_r + 4'h1;
                    shreg_nxt = {shreg_r[`SADC_DATA_W-2:0], 1'h0};
                    dout_nxt = shreg_r[`SADC_DATA_W-2];
                    if (falls_r == `SADC_SAMPLE_FALL) begin
                        sample_nxt = 1'h1;
                        chan_nxt = new_addr_r;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            phase_r <= sadc_pkg::SADC_PH_OFF;
            falls_r <= 4'h0;
            shreg_r <= 8'h00;
            new_addr_r <= 5'h00;
            chan_r <= 5'h00;
            conv_ch_r <= 5'h00;
            sample_r <= 1'h0;
            busy_r <= 1'h0;
            conv_cnt_r <= 6'h00;
            result_r <= 8'h00;
            done_r <= 1'h0;
            dout_r <= 1'h0;
            oe_n_r <= 1'h1;
        end else begin
            phase_r <= phase_nxt;
            falls_r <= falls_nxt;
            shreg_r <= shreg_nxt;
            new_addr_r <= new_addr_nxt;
            chan_r <= chan_nxt;
            conv_ch_r <= conv_ch_nxt;
            sample_r <= sample_nxt;
            busy_r <= busy_nxt;
            conv_cnt_r <= conv_cnt_nxt;
            result_r <= result_nxt;
            done_r <= done_nxt;
            dout_r <= dout_nxt;
            oe_n_r <= oe_n_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flip-flops.
    // ------------------------------------------------------------------
    assign link.dout = dout_r;
    assign link.dout_oe_n = oe_n_r;
    assign chan_o = chan_r;
    assign sample_o = sample_r;
    assign convert_o = busy_r;
    assign result_o = result_r;
    assign done_o = done_r;

endmodule

// File: rtl/sadc_host.sv
// Host end: makes both link clocks and runs one control sequence per request.
`timescale 1ns/1ns
`include "sadc_cfg.svh"

module sadc_host (
    input wire logic clk_i, // System clock, 125 MHz.
    input wire logic resetn_i, // Asynchronous reset, active low.
    sadc_if.host link, // Serial control link.
    input wire logic start_i, // Request one conversion frame.
    input wire logic [`SADC_ADDR_W-1:0] chan_i, // Channel for the frame.
    input wire logic common_i, // Drive one clock on both clock pins.
    output logic busy_o, // Frame in progress.
    output logic [`SADC_DATA_W-1:0] data_o, // Result read in the frame.
    output logic valid_o // One-cycle pulse, data_o updated.
);

    // ------------------------------------------------------------------
    // Clock dividers, line synchroniser and sequencer.
    // ------------------------------------------------------------------
    sadc_pkg::sadc_hstate_e st_r;
    sadc_pkg::sadc_hstate_e st_nxt;
    logic [3:0] sys_cnt_r;
    logic [3:0] sys_cnt_nxt;
    logic sys_r;
    logic sys_nxt;
    logic [3:0] io_cnt_r;
    logic [3:0] io_cnt_nxt;
    logic io_r;
    logic io_nxt;
    logic cs_n_r;
    logic cs_n_nxt;
    logic [`SADC_ADDR_W-1:0] addr_sh_r;
    logic [`SADC_ADDR_W-1:0] addr_sh_nxt;
    logic common_r;
    logic common_nxt;
    logic [3:0] bit_r;
    logic [3:0] bit_nxt;
    logic [5:0] wait_r;
    logic [5:0] wait_nxt;
    logic [`SADC_DATA_W-1:0] rx_r;
    logic [`SADC_DATA_W-1:0] rx_nxt;
    logic [`SADC_DATA_W-1:0] data_r;
    logic [`SADC_DATA_W-1:0] data_nxt;
    logic valid_r;
    logic valid_nxt;
    logic busy_r;
    logic busy_nxt;
    logic din1_r;
    logic din2_r;
    logic sys_tick;
    logic sys_fall;
    logic io_tick;
    logic io_lvl;

    // The returning line is a pin, so it passes two flip-flops.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            din1_r <= 1'h1;
            din2_r <= 1'h1;
        end else begin
            din1_r <= link.dout_line;
            din2_r <= din1_r;
        end
    end

    // The conversion clock runs free so a conversion can always finish.
    assign sys_tick = (sys_cnt_r == (`SADC_SYS_HALF - 4'h1));
    assign sys_fall = sys_tick && sys_r;
    assign io_lvl = common_r ? sys_r : io_r;
    assign io_tick = common_r ? sys_tick : (io_cnt_r == (`SADC_IO_HALF - 4'h1));

    always_comb begin
        sys_cnt_nxt = sys_tick ? 4'h0 : sys_cnt_r + 4'h1;
        sys_nxt = sys_r ^ sys_tick;
        st_nxt = st_r;
        io_cnt_nxt = 4'h0;
        io_nxt = 1'h0;
        cs_n_nxt = cs_n_r;
        addr_sh_nxt = addr_sh_r;
        common_nxt = common_r;
        bit_nxt = bit_r;
        wait_nxt = wait_r;
        rx_nxt = rx_r;
        data_nxt = data_r;
        valid_nxt = 1'h0;
        busy_nxt = busy_r;

        unique case (st_r)
            sadc_pkg::SADC_H_IDLE: begin
                busy_nxt = 1'h0;
                // Select drops on the same clock edge as a conversion-clock fall so the
                // shared-clock count of skipped clocks is exact.
                if (start_i && sys_fall) begin
                    cs_n_nxt = 1'h0;
                    addr_sh_nxt = chan_i;
                    common_nxt = common_i;
                    wait_nxt = 6'h0;
                    busy_nxt = 1'h1;
                    st_nxt = sadc_pkg::SADC_H_SEL;
                end
            end
            sadc_pkg::SADC_H_SEL: begin
                if (sys_fall) begin
                    wait_nxt = wait_r + 6'h1;
                    if ((common_r && (wait_nxt == `SADC_SEL_FALLS_COMMON)) ||
                        (!common_r && (wait_nxt == `SADC_SEL_FALLS_NORM))) begin
                        bit_nxt = 4'h0;
                        st_nxt = sadc_pkg::SADC_H_SHIFT;
                    end
                end
            end
            sadc_pkg::SADC_H_SHIFT: begin
                io_cnt_nxt = io_tick ? 4'h0 : io_cnt_r + 4'h1;
                io_nxt = io_r ^ io_tick;
                // Each fall reads the bit offered since the previous one,
                // then presents the next address bit, MSB first.
                if (io_tick && io_lvl) begin
                    rx_nxt = {rx_r[`SADC_DATA_W-2:0], din2_r};
                    addr_sh_nxt = {addr_sh_r[`SADC_ADDR_W-2:0], 1'h0};
                    bit_nxt = bit_r + 4'h1;
                    if (bit_r == `SADC_LAST_FALL) begin
                        cs_n_nxt = 1'h1;
                        wait_nxt = 6'h0;
                        st_nxt = sadc_pkg::SADC_H_CONV;
                    end
                end
            end
            sadc_pkg::SADC_H_CONV: begin
                // Select stays high across the whole conversion.
                if (sys_fall) begin
                    wait_nxt = wait_r + 6'h1;
                    if (wait_nxt == `SADC_CONV_WAIT) begin
                        data_nxt = rx_r;
                        valid_nxt = 1'h1;
                        busy_nxt = 1'h0;
                        st_nxt = sadc_pkg::SADC_H_IDLE;
                    end
                end
            end
        endcase

        // A shared clock copies the conversion clock onto the shift pin.
        if (common_r) begin
            io_nxt = sys_nxt;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r <= sadc_pkg::SADC_H_IDLE;
            sys_cnt_r <= 4'h0;
            sys_r <= 1'h0;
            io_cnt_r <= 4'h0;
            io_r <= 1'h0;
            cs_n_r <= 1'h1;
            addr_sh_r <= 5'h00;
            common_r <= 1'h0;
            bit_r <= 4'h0;
            wait_r <= 6'h00;
            rx_r <= 8'h00;
            data_r <= 8'h00;
            valid_r <= 1'h0;
            busy_r <= 1'h0;
        end else begin
            st_r <= st_nxt;
            sys_cnt_r <= sys_cnt_nxt;
            sys_r <= sys_nxt;
            io_cnt_r <= io_cnt_nxt;
            io_r <= io_nxt;
            cs_n_r <= cs_n_nxt;
            addr_sh_r <= addr_sh_nxt;
            common_r <= common_nxt;
            bit_r <= bit_nxt;
            wait_r <= wait_nxt;
            rx_r <= rx_nxt;
            data_r <= data_nxt;
            valid_r <= valid_nxt;
            busy_r <= busy_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs; the shift clock is clean by construction.
    // ------------------------------------------------------------------
    assign link.cs_n = cs_n_r;
    assign link.addr = addr_sh_r[`SADC_ADDR_W-1];
    assign link.io_clk = io_r;
    assign link.sys_clk = sys_r;
    assign busy_o = busy_r;
    assign data_o = data_r;
    assign valid_o = valid_r;

endmodule

// File: dv/sadc_asserts.sv
// Concurrent checks on the serial link between the converter device and its host.
`timescale 1ns/1ns
module sadc_asserts (
    input wire logic clk_i, // System clock.
    input wire logic resetn_i, // Reset, active low.
    input wire logic cs_n, // Select, active low.
    input wire logic addr, // Address bit.
    input wire logic io_clk, // Shift clock.
    input wire logic sys_clk, // Conversion clock.
    input wire logic dout, // Device data bit.
    input wire logic dout_oe_n, // Device drive enable, low drives.
    input wire logic dout_line // Resolved data line.
);
    logic [9:0] hi_cnt_r;
    logic [3:0] age_r;
    logic [3:0] nfall_r;
    logic io_q_r;
    logic cs_q_r;
    logic io_fell;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // ---------------------------------------------------------------
    // Helper counters.
    // ---------------------------------------------------------------
    // The high-time and fall-age counters saturate so a long idle select never wraps into a false alarm.
    assign io_fell = io_q_r && !io_clk;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hi_cnt_r <= 10'h3ff;
            age_r <= 4'hf;
            nfall_r <= 4'h0;
            io_q_r <= 1'b0;
            cs_q_r <= 1'b1;
        end else begin
            io_q_r <= io_clk;
            cs_q_r <= cs_n;
            hi_cnt_r <= !cs_n ? 10'h000 : (hi_cnt_r == 10'h3ff ? hi_cnt_r : hi_cnt_r + 10'h001);
            age_r <= io_fell ? 4'h0 : (age_r == 4'hf ? age_r : age_r + 4'h1);
            // The fall that coincides with the select drop is not a shift cycle.
            nfall_r <= cs_q_r ? 4'h0 : nfall_r + {3'h0, io_fell};
        end
    end

    // ---------------------------------------------------------------
    // Properties.
    // ---------------------------------------------------------------
    property p_float; hi_cnt_r >= 10'h040 |-> dout_oe_n; endproperty
    a_float: assert property (p_float)
        else $error("data line driven while deselected");
    property p_recog_wait; $fell(cs_n) |-> dout_oe_n [*8]; endproperty
    a_recog_wait: assert property (p_recog_wait)
        else $error("select taken without clock filtering");
    property p_recog_bound; $fell(cs_n) |-> ##[1:64] !dout_oe_n; endproperty
    a_recog_bound: assert property (p_recog_bound)
        else $error("select low never recognized");
    property p_release; $rose(cs_n) |-> ##[1:64] dout_oe_n; endproperty
    a_release: assert property (p_release)
        else $error("line not released after select high");
    property p_shift; $changed(dout) && !dout_oe_n && !$past(dout_oe_n) |-> age_r <= 4'h6; endproperty
    a_shift: assert property (p_shift)
        else $error("data bit changed away from a shift fall");
    property p_io_half; $changed(io_clk) |=> $stable(io_clk) [*7]; endproperty
    a_io_half: assert property (p_io_half)
        else $error("shift clock glitch");
    property p_sys_half; $changed(sys_clk) |=> $stable(sys_clk) [*7]; endproperty
    a_sys_half: assert property (p_sys_half)
        else $error("conversion clock glitch");
    property p_hold_high; $fell(cs_n) |-> hi_cnt_r >= 10'h240; endproperty
    a_hold_high: assert property (p_hold_high)
        else $error("select lowered before conversion end");
    property p_frame; $rose(cs_n) |=> nfall_r == 4'h8 || nfall_r == 4'ha; endproperty
    a_frame: assert property (p_frame)
        else $error("wrong shift count in frame");

    c_normal: cover property ($rose(cs_n) ##1 nfall_r == 4'h8);
    c_common: cover property ($rose(cs_n) ##1 nfall_r == 4'ha);
    c_drive: cover property ($fell(dout_oe_n));
endmodule

// File: dv/testbench.sv
// Self-checking bench joining the converter device and its host over one link.
`timescale 1ns/1ns
`include "sadc_cfg.svh"
module testbench;
    logic clk_i, resetn_i, start_i, common_i, io_q, cs_q;
    logic sample_o, convert_o, done_o, busy_o, valid_o;
    logic [4:0] chan_i, chan_o;
    logic [7:0] conv_data_i, result_o, data_o, wire_rx, prev;
    logic [4:0] t_ch [6] = '{5'h00, 5'h12, 5'h13, 5'h07, 5'h13, 5'h01};
    logic t_cm [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [7:0] t_code [6] = '{8'h5a, 8'ha5, 8'h33, 8'hff, 8'h01, 8'h3c};
    int n_errors = 0;
    int samples_checked = 0;

    sadc_if link();
    sadc_dev sadc_dev_inst (.clk_i(clk_i), .resetn_i(resetn_i), .link(link),
        .conv_data_i(conv_data_i), .chan_o(chan_o), .sample_o(sample_o),
        .convert_o(convert_o), .result_o(result_o), .done_o(done_o));
    sadc_host sadc_host_inst (.clk_i(clk_i), .resetn_i(resetn_i), .link(link), .start_i(start_i),
        .chan_i(chan_i), .common_i(common_i), .busy_o(busy_o), .data_o(data_o), .valid_o(valid_o));
    sadc_asserts sadc_asserts_inst (.clk_i(clk_i), .resetn_i(resetn_i), .cs_n(link.cs_n),
        .addr(link.addr), .io_clk(link.io_clk), .sys_clk(link.sys_clk), .dout(link.dout),
        .dout_oe_n(link.dout_oe_n), .dout_line(link.dout_line));

    // 125 MHz system clock.
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // Capture the line at each shift fall, as a listener on the wire would.
    always @(posedge clk_i) begin
        io_q <= link.io_clk;
        cs_q <= link.cs_n;
        if (io_q && !link.io_clk && (!link.cs_n || !cs_q)) begin
            wire_rx <= {wire_rx[6:0], link.dout_line};
        end
    end

    // ---------------------------------------------------------------
    // Tasks.
    // ---------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One frame: returns the previous result and converts the new channel.
    task automatic frame(input logic [4:0] ch, input logic cm, input logic [7:0] code);
        logic [2:0] seen;
        logic [7:0] exp;
        int i;
        seen = 3'h0;
        exp = (ch == `SADC_SELF_TEST_CH) ? `SADC_SELF_TEST_CODE : code;
        @(posedge clk_i);
        chan_i <= ch;
        common_i <= cm;
        conv_data_i <= code;
        start_i <= 1'b1;
        for (i = 0; i < 3000 && valid_o !== 1'b1; i++) begin
            @(posedge clk_i);
            if (busy_o === 1'b1) begin
                start_i <= 1'b0;
            end
            seen = seen | {sample_o === 1'b1, convert_o === 1'b1, done_o === 1'b1};
            if (done_o === 1'b1) begin
                chk(result_o, exp);
            end
        end
        // A hung frame counts once and the run goes on to the closing report.
        if (i >= 3000) begin
            n_errors++;
            $display("[FAIL] %0t frame never completed", $time);
            return;
        end
        chk(data_o, prev);
        chk(wire_rx, prev);
        chk({3'h0, chan_o}, {3'h0, ch});
        chk({5'h00, seen}, 8'h07);
        chk({5'h00, busy_o, link.dout_oe_n, link.dout_line}, 8'h03);
        prev = exp;
    endtask

    // ---------------------------------------------------------------
    // Main sequence: frames in normal and common clock mode.
    // ---------------------------------------------------------------
    initial begin
        resetn_i = 1'b0;
        start_i = 1'b0;
        chan_i = 5'h00;
        common_i = 1'b0;
        conv_data_i = 8'h00;
        prev = 8'h00;
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            frame(t_ch[k], t_cm[k], t_code[k]);
            $display("test %0d done", k);
        end
        finish_test();
    end
endmodule
